// ===== irq_arb_pkg.sv
// shared constants, types and helpers of the vectored interrupt arbiter
package irq_arb_pkg;
   localparam int SRC_NUM = 9;
   localparam logic [7:0] INTERRUPT_JAM_OPCODE_OPCODE = 8'h00;
   localparam logic [14:0] IRQ_ENTRY_PC = 15'h00FF;
   localparam logic [2:0] SEQ_CYCLES = 3'h7;
   localparam logic [7:0] LAST_IN_PAGE = 8'hFF;
   // register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_IRQ_EN = 12'h004;
   localparam logic [11:0] OFS_IRQ_PEND = 12'h008;
   localparam logic [11:0] OFS_WAKE_EN = 12'h00C;
   localparam logic [11:0] OFS_WAKE_PEND = 12'h010;
   localparam logic [11:0] OFS_STATUS = 12'h014;
   // control bit positions
   localparam int CTRL_GIE = 0;
   localparam int CTRL_PORTL_GROUP_IRQ_ENABLE = 1;
   localparam int CTRL_EXT_FALL = 2;
   // table slots, low byte of the entry is {3'b111, slot, 0}
   localparam logic [3:0] SLOT_TRAP = 4'hF;
   localparam logic [3:0] SLOT_PORTL = 4'h1;
   localparam logic [3:0] SLOT_DEFAULT = 4'h0;
   // source bit order: ext, idle, t1a, t1b, serial, t2a, t2b, t3a, t3b
   localparam logic [3:0] SLOT_MAP [SRC_NUM] = '{4'hD, 4'hC, 4'hB, 4'hA, 4'h9,
      4'h5, 4'h4, 4'h3, 4'h2};

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_RUN = 2'b10
   } seq_state_t;

   typedef struct packed {
      logic instrStart;
      logic opcodeValid;
      logic [7:0] opcode;
      logic [14:0] pc;
      logic visExec;
      logic retiExec;
      logic clearTrapExec;
   } core_req_t;

   typedef struct packed {
      logic jam;
      logic [7:0] jamOpcode;
      logic push;
      logic [14:0] pushAddr;
      logic pcLoad;
      logic [14:0] pcValue;
      logic vecValid;
      logic [14:0] vecAddr;
   } seq_out_t;

   // highest ranked active source picks the slot; trap beats all
   function automatic logic [3:0] pick_slot(input logic trap, input logic [SRC_NUM-1:0] act,
                                            input logic portl);
      logic [3:0] pick;
      pick = portl ? SLOT_PORTL : SLOT_DEFAULT;
      for (int i = SRC_NUM - 1; i >= 0; i--) begin
         if (act[i]) begin
            pick = SLOT_MAP[i];
         end
      end
      if (trap) begin
         pick = SLOT_TRAP;
      end
      return pick;
   endfunction
endpackage

// ===== vectored_interrupt_arbiter.sv
// vectored interrupt arbiter with apb register access
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_arbiter
   import irq_arb_pkg::*;
(
   input wire logic clk_sys, // system clock, 50 MHz
   input wire logic resetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic external_irq_pin, // asynchronous edge source
   input wire logic [SRC_NUM-2:0] srcEvent, // one-cycle events, idle timer to t3b
   input wire logic [7:0] portlEdge, // one-cycle port-l wake edges
   input wire core_req_t coreReq, // sequencer reports
   output seq_out_t seqOut // sequencer commands
);
   logic rstMeta, rstSyncN;
   logic [2:0] pinSync;
   logic extLevelReg, extLevelNext;
   logic [3:0] fillReg, fillNext;
   logic readyReg, readyNext, errReg, errNext;
   logic [31:0] rdataReg, rdataNext;
   logic gieReg, gieNext, lpenReg, lpenNext, fallReg, fallNext;
   logic [SRC_NUM-1:0] enReg, enNext, pendReg, pendNext, active;
   logic [7:0] wakeEnReg, wakeEnNext, wakePendReg, wakePendNext;
   logic trapReg, trapNext;
   seq_state_t stateReg, stateNext;
   logic [2:0] cntReg, cntNext;
   seq_out_t outReg, outNext;
   logic wr, mapped, extEvent, portlActive, anyActive;
   logic trapFetch, startIrq, startTrap;
   logic [3:0] slot;
   logic [6:0] page;

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   // arbitration terms
   always_comb begin
      active = enReg & pendReg;
      portlActive = lpenReg & (|(wakeEnReg & wakePendReg));
      anyActive = (|active) | portlActive;
      trapFetch = coreReq.opcodeValid && (coreReq.opcode == INTERRUPT_JAM_OPCODE_OPCODE);
      // maskable start held off by a pending trap
      startIrq = coreReq.instrStart && gieReg && anyActive && !trapReg && !trapFetch
                 && (stateReg == SEQ_IDLE);
      startTrap = trapFetch && (stateReg == SEQ_IDLE);
      slot = pick_slot(trapReg, active, portlActive);
      // an instruction at the last byte of a page (pc low byte FF) takes its table from the next page
      page = coreReq.pc[14:8] + 7'((coreReq.pc[7:0] == LAST_IN_PAGE));
   end

   // pin edge detector; the level is trusted only once the sync chain holds real
   // samples, so a pin that sits high through reset raises no false edge
   always_comb begin
      fillNext = {fillReg[2:0], 1'b1};
      extLevelNext = extLevelReg;
      if (!fillReg[3] || (pinSync[1] == pinSync[2])) begin
         extLevelNext = pinSync[2];
      end
      extEvent = fillReg[3] && (extLevelNext != extLevelReg) && (extLevelNext != fallReg);
   end

   // pin synchroniser and level register
   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         pinSync <= 3'h0;
         fillReg <= 4'h0;
         extLevelReg <= 1'b0;
      end else begin
         pinSync <= {pinSync[1:0], external_irq_pin};
         fillReg <= fillNext;
         extLevelReg <= extLevelNext;
      end
   end

   // apb slave: one wait state, read data and error captured with ready
   always_comb begin
      wr = psel && penable && readyReg && pwrite;
      readyNext = psel && penable && !readyReg;
      mapped = 1'b1;
      rdataNext = 32'h0000_0000;
      case (paddr)
         OFS_CTRL: rdataNext = 32'({fallReg, lpenReg, gieReg});
         OFS_IRQ_EN: rdataNext = 32'(enReg);
         OFS_IRQ_PEND: rdataNext = 32'(pendReg);
         OFS_WAKE_EN: rdataNext = 32'(wakeEnReg);
         OFS_WAKE_PEND: rdataNext = 32'(wakePendReg);
         OFS_STATUS: rdataNext = 32'({slot, 2'b00, (stateReg == SEQ_RUN), trapReg});
         default: mapped = 1'b0;
      endcase
      if (!readyNext) begin
         rdataNext = rdataReg;
      end
      errNext = readyNext ? !mapped : errReg;
   end

   // apb response registers
   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         readyReg <= 1'b0;
         errReg <= 1'b0;
         rdataReg <= 32'h0000_0000;
      end else begin
         readyReg <= readyNext;
         errReg <= errNext;
         rdataReg <= rdataNext;
      end
   end

   // software registers, pending bits and the global enable
   always_comb begin
      gieNext = gieReg;
      lpenNext = lpenReg;
      fallNext = fallReg;
      enNext = enReg;
      wakeEnNext = wakeEnReg;
      pendNext = pendReg;
      wakePendNext = wakePendReg;
      if (wr) begin
         case (paddr)
            OFS_CTRL: begin
               gieNext = pwdata[CTRL_GIE];
               lpenNext = pwdata[CTRL_PORTL_GROUP_IRQ_ENABLE];
               fallNext = pwdata[CTRL_EXT_FALL];
            end
            OFS_IRQ_EN: enNext = pwdata[SRC_NUM-1:0];
            OFS_IRQ_PEND: pendNext = pendReg & ~pwdata[SRC_NUM-1:0];
            OFS_WAKE_EN: wakeEnNext = pwdata[7:0];
            OFS_WAKE_PEND: wakePendNext = wakePendReg & ~pwdata[7:0];
            default: ;
         endcase
      end
      // events set after the clear so a same-cycle event survives
      pendNext = pendNext | {srcEvent, extEvent};
      wakePendNext = wakePendNext | portlEdge;
      if (coreReq.retiExec) begin
         gieNext = 1'b1;
      end
      if (startIrq) begin
         gieNext = 1'b0;
      end
   end

   // software visible state
   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         gieReg <= 1'b0;
         lpenReg <= 1'b0;
         fallReg <= 1'b0;
         enReg <= '0;
         pendReg <= '0;
         wakeEnReg <= 8'h00;
         wakePendReg <= 8'h00;
      end else begin
         gieReg <= gieNext;
         lpenReg <= lpenNext;
         fallReg <= fallNext;
         enReg <= enNext;
         pendReg <= pendNext;
         wakeEnReg <= wakeEnNext;
         wakePendReg <= wakePendNext;
      end
   end

   // hidden trap flag; a fetch in the same cycle as the clear keeps it set
   always_comb begin
      trapNext = trapReg;
      if (coreReq.clearTrapExec) begin
         trapNext = 1'b0;
      end
      if (trapFetch) begin
         trapNext = 1'b1;
      end
   end

   // trap flag register, cleared by reset as well
   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         trapReg <= 1'b0;
      end else begin
         trapReg <= trapNext;
      end
   end

   // entry sequencer and vector output
   always_comb begin
      stateNext = stateReg;
      cntNext = cntReg;
      outNext = outReg;
      outNext.jam = 1'b0;
      outNext.push = 1'b0;
      outNext.pcLoad = 1'b0;
      outNext.vecValid = 1'b0;
      outNext.jamOpcode = INTERRUPT_JAM_OPCODE_OPCODE;
      outNext.pcValue = IRQ_ENTRY_PC;
      case (stateReg)
         SEQ_IDLE: begin
            if (startIrq || startTrap) begin
               stateNext = SEQ_RUN;
               cntNext = 3'h0;
               outNext.jam = startIrq;
               outNext.push = 1'b1;
               outNext.pushAddr = coreReq.pc;
            end
         end
         SEQ_RUN: begin
            cntNext = cntReg + 3'h1;
            outNext.pcLoad = (cntReg == SEQ_CYCLES - 3'h2);
            if (cntReg == SEQ_CYCLES - 3'h1) begin
               stateNext = SEQ_IDLE;
            end
         end
         default: stateNext = SEQ_IDLE;
      endcase
      if (coreReq.visExec) begin
         outNext.vecValid = 1'b1;
         outNext.vecAddr = {page, 3'b111, slot, 1'b0};
      end
   end

   // sequencer registers; every command output leaves straight from here
   always_ff @(posedge clk_sys or negedge rstSyncN) begin
      if (!rstSyncN) begin
         stateReg <= SEQ_IDLE;
         cntReg <= 3'h0;
         outReg <= '0;
      end else begin
         stateReg <= stateNext;
         cntReg <= cntNext;
         outReg <= outNext;
      end
   end

   assign prdata = rdataReg;
   assign pready = readyReg;
   assign pslverr = errReg;
   assign seqOut = outReg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstSyncN);

   jam_on_start_a: assert property (coreReq.instrStart && gieReg && anyActive && !trapReg
      && !trapFetch && stateReg == SEQ_IDLE |=> outReg.jam && !gieReg)
      else $error("interrupt not taken at instruction start");
   jam_opcode_a: assert property (outReg.jam |-> outReg.jamOpcode == 8'h00)
      else $error("jammed opcode is not the interrupt opcode");
   seq_length_a: assert property (outReg.push |-> ##6 outReg.pcLoad
      && outReg.pcValue == 15'h00FF ##1 stateReg == SEQ_IDLE)
      else $error("entry sequence length or target wrong");
   mask_hold_a: assert property (!gieReg && !trapFetch |=> !outReg.jam)
      else $error("maskable interrupt taken with gie clear");
   trap_set_a: assert property (trapFetch |=> trapReg && $stable(gieReg)
      || $past(coreReq.retiExec) || $past(wr))
      else $error("trap fetch did not set hidden flag");
   trap_block_a: assert property (trapReg && coreReq.instrStart |=> !outReg.jam)
      else $error("maskable interrupt ran during trap");
   vis_trap_a: assert property (coreReq.visExec && trapReg |=> outReg.vecValid
      && outReg.vecAddr[7:0] == 8'hFE)
      else $error("vector select missed trap entry");
   vis_default_a: assert property (coreReq.visExec && !trapReg && !anyActive
      |=> outReg.vecAddr[7:0] == 8'hE0)
      else $error("default entry not selected");
   vis_page_a: assert property (coreReq.visExec |=> outReg.vecAddr[14:8] ==
      $past(coreReq.pc[14:8]) + 7'(($past(coreReq.pc[7:0]) == 8'hFF)))
      else $error("vector page wrong");
   return_from_irq_gie_a: assert property (coreReq.retiExec && !startIrq && !wr |=> gieReg)
      else $error("return did not set gie");
   trap_clear_a: assert property (coreReq.clearTrapExec && !trapFetch |=> !trapReg)
      else $error("trap flag not cleared");
   pend_hold_a: assert property (!wr |=> (pendReg & $past(pendReg)) == $past(pendReg))
      else $error("pending bit lost without a clear");
endmodule
`default_nettype wire

// ===== core_model.sv
// processor sequencer model: instruction starts and commanded core events
`timescale 1ns/1ps
`default_nettype none
module core_model
   import irq_arb_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic resetn, // reset, active low
   input wire logic [2:0] cmd, // 1 vis, 2 return_from_irq, 3 clear trap, 4 fetch 00
   input wire logic [14:0] pc, // address of the pending instruction
   input wire seq_out_t seqOut, // arbiter commands
   output core_req_t coreReq // reports to the arbiter
);
   logic [1:0] gap;
   logic hold;
   // a start every fourth cycle, none while an entry sequence owns the core
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         coreReq <= '0;
         gap <= 2'h0;
         hold <= 1'b0;
      end else begin
         gap <= gap + 2'h1;
         hold <= (hold | seqOut.push) & ~seqOut.pcLoad;
         coreReq.instrStart <= gap == 2'h3 && !hold && !seqOut.push;
         coreReq.pc <= pc;
         coreReq.visExec <= cmd == 3'h1;
         coreReq.retiExec <= cmd == 3'h2;
         coreReq.clearTrapExec <= cmd == 3'h3;
         coreReq.opcodeValid <= cmd == 3'h4;
         coreReq.opcode <= cmd == 3'h4 ? INTERRUPT_JAM_OPCODE_OPCODE : 8'hC3;
      end
   end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench of the vectored interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import irq_arb_pkg::*;
;
   logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, extPin = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr;
   logic [7:0] srcEvent = '0, portlEdge = '0;
   logic [2:0] cmd = '0;
   logic [14:0] pc = 15'h0100;
   core_req_t coreReq;
   seq_out_t seqOut;
   logic [32:0] rdQ[$], vecQ[$], pushQ[$];
   int n_mismatch = 0, samples_checked = 0, cyc = 0, pushCyc = 0;
   // table low bytes by source rank, idle timer down to t3b
   logic [7:0] tbl [8] = '{8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hEA, 8'hE8, 8'hE6, 8'hE4};
   always #10 clk_sys = ~clk_sys;
   vectored_interrupt_arbiter vectored_interrupt_arbiter_i (.clk_sys(clk_sys), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_irq_pin(extPin),
      .srcEvent(srcEvent), .portlEdge(portlEdge), .coreReq(coreReq), .seqOut(seqOut));
   core_model core_model_i (.clk_sys(clk_sys), .resetn(resetn), .cmd(cmd), .pc(pc),
      .seqOut(seqOut), .coreReq(coreReq));
   task cmp(input logic [32:0] e, input logic [32:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // one compare per kind of result, all counted by the same tally
   task cmp_read(input logic [32:0] e, input logic [32:0] g);
      cmp(e, g);
   endtask
   task cmp_vec(input logic [32:0] e, input logic [32:0] g);
      cmp(e, g);
   endtask
   task cmp_entry(input logic [32:0] e, input logic [32:0] g);
      cmp(e, g);
   endtask
   // results are judged at the edge where they are sampled, oldest note first
   always @(posedge clk_sys) begin
      cyc++;
      if (pready === 1'b1 && pwrite === 1'b0) cmp_read(rdQ.pop_front(), {pslverr, prdata});
      if (seqOut.vecValid === 1'b1) cmp_vec(vecQ.pop_front(), 33'(seqOut.vecAddr));
      if (seqOut.push === 1'b1) begin
         cmp_entry(pushQ.pop_front(),
            33'({seqOut.jam, seqOut.jamOpcode, seqOut.pushAddr}));
         pushCyc = cyc;
      end
      if (seqOut.pcLoad === 1'b1) begin
         cmp_entry({18'h6, IRQ_ENTRY_PC}, {18'(cyc - pushCyc), seqOut.pcValue});
      end
   end
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [32:0] e);
      rdQ.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task vector_select_instruction(input logic [14:0] p, input logic [7:0] lo);
      vecQ.push_back(33'({p[14:8] + 7'(p[7:0] == 8'hFF), lo}));
      @(posedge clk_sys);
      cmd <= 3'h1;
      pc <= p;
      @(posedge clk_sys);
      cmd <= 3'h0;
      repeat (4) @(posedge clk_sys);
   endtask
   task op(input logic [2:0] c);
      @(posedge clk_sys);
      cmd <= c;
      @(posedge clk_sys);
      cmd <= 3'h0;
      repeat (20) @(posedge clk_sys);
   endtask
   task ev(input logic [7:0] s, input logic [7:0] l);
      @(posedge clk_sys);
      srcEvent <= s;
      portlEdge <= l;
      @(posedge clk_sys);
      srcEvent <= 8'h0;
      portlEdge <= 8'h0;
      repeat (2) @(posedge clk_sys);
   endtask
   task note(input logic j);
      pushQ.push_back(33'({j, INTERRUPT_JAM_OPCODE_OPCODE, pc}));
   endtask
   task tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'hEDED));
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      pc <= {7'($urandom % 126 + 1), 8'($urandom % 255)};
      repeat (5) @(posedge clk_sys);
      rd(OFS_CTRL, 33'h0);
      rd(12'h040, 33'h1_0000_0000);
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         wr(OFS_IRQ_EN, 32'h1 << (k + 1));
         ev(8'h1 << k, 8'h0);
         vector_select_instruction(pc, tbl[k]);
         wr(OFS_IRQ_PEND, 32'h1 << (k + 1));
      end
      ev(8'h02, 8'h0);
      vector_select_instruction(pc, 8'hE0);
      wr(OFS_IRQ_PEND, 32'h1FF);
      wr(OFS_WAKE_EN, 32'h1);
      ev(8'h0, 8'h01);
      vector_select_instruction(pc, 8'hE0);
      wr(OFS_CTRL, 32'h2);
      vector_select_instruction(pc, 8'hE2);
      wr(OFS_WAKE_PEND, 32'hFF);
      wr(OFS_CTRL, 32'h0);
      $display("test ranking done");
      wr(OFS_IRQ_EN, 32'h1FF);
      ev(8'h80, 8'h0);
      @(posedge clk_sys);
      extPin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      vector_select_instruction(pc, 8'hFA);
      vector_select_instruction({pc[14:8], 8'hFF}, 8'hFA);
      note(1'b1);
      wr(OFS_CTRL, 32'h1);
      repeat (20) @(posedge clk_sys);
      rd(OFS_CTRL, 33'h0);
      wr(OFS_IRQ_PEND, 32'h1);
      note(1'b1);
      op(3'h2);
      wr(OFS_IRQ_PEND, 32'h100);
      op(3'h2);
      rd(OFS_CTRL, 33'h1);
      $display("test entry done");
      note(1'b0);
      op(3'h4);
      ev(8'h01, 8'h0);
      rd(OFS_CTRL, 33'h1);
      rd(OFS_STATUS, 33'hF1);
      vector_select_instruction(pc, 8'hFE);
      note(1'b1);
      op(3'h3);
      rd(OFS_STATUS, 33'hC0);
      $display("test trap done");
      // reset in mid-run with the pin high must leave no false edge behind
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rd(OFS_STATUS, 33'h0);
      rd(OFS_CTRL, 33'h0);
      rd(OFS_IRQ_PEND, 33'h0);
      wr(OFS_CTRL, 32'h4);
      @(posedge clk_sys);
      extPin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(OFS_IRQ_PEND, 33'h1);
      $display("test reset and edge done");
      repeat (2) @(posedge clk_sys);
      cmp(33'h0, 33'(rdQ.size() + vecQ.size() + pushQ.size()));
      tally_and_finish;
   end
endmodule
`default_nettype wire
